// ===== core/aux_pin_function_mux.sv
// Purpose: aux pin function selector plus serial-mode main port pin roles
// Assumes: 20 MHz clock; divided clocks come from a 60 MHz source clock input
// Notes: the uart datapath sits outside and reports its busy levels here
// How it works
// RULE1: aux functions taken only when config fitted
// RULE2: defaults pull-up, pin seven pull-down
// RULE3: line driver on bit early, off after stop
// RULE4: power_on_n low configured, high suspended
// RULE5: tx led pulses low on transmit
// RULE6: rx led pulses low on receive
// RULE7: traffic led pulses on either direction
// RULE8: sleep output low during suspend
// RULE9: clocks at half, quarter, eighth rate
// RULE10: selected clocks stop in suspend
// RULE11: fixed levels, pulled-up input, bit-bang
// RULE12: serial mode is the default
// RULE13: main port txd rxd rts cts
// RULE14: main port dtr dsr dcd ring
// RULE15: ring low wakes host when enabled
// RULE16: suspend pull-down blocks the wake
// RULE17: board keeps inputs pulled up in suspend
`timescale 1ns/1ps
`include "aux_mux_cfg.svh"
module aux_pin_function_mux #(
   parameter int AUX_PINS      = 10,
   parameter int LED_PULSE_CYC = `LED_PULSE_CYC
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                src_clock,
   input  wire logic                usb_configured,
   input  wire logic                usb_suspended,
   input  wire logic                uart_txd,
   input  wire logic                uart_tx_early,
   input  wire logic                uart_tx_busy,
   input  wire logic                uart_rx_busy,
   output logic                     uart_rxd,
   output logic                     uart_cts_n,
   output logic                     main_port_pin_txd,
   input  wire logic                main_port_pin_rxd,
   output logic                     main_port_pin_rts_n,
   input  wire logic                main_port_pin_cts_n,
   output logic                     main_port_pin_dtr_n,
   input  wire logic                main_port_pin_dsr_n,
   input  wire logic                carrier_detect_n,
   input  wire logic                ring_indicator_n,
   output logic                     wake_request,
   output logic                     suspend_pull_down,
   input  wire logic [AUX_PINS-1:0] aux_port_pin_in,
   output logic      [AUX_PINS-1:0] aux_port_pin_out,
   output logic      [AUX_PINS-1:0] aux_port_pin_oe,
   output logic      [AUX_PINS-1:0] aux_port_pin_pull_up,
   output logic      [AUX_PINS-1:0] aux_port_pin_pull_down,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   import aux_mux_pkg::*;

   localparam int SYNC_W = 5 + AUX_PINS;

   // ------------------------------------------------------------
   // register file over AXI4-Lite
   // ------------------------------------------------------------
   logic [31:0]         ctrl_reg, ctrl_next;
   logic [63:0]         func_reg, func_next;
   logic [AUX_PINS-1:0] bb_out_reg, bb_out_next, bb_dir_reg, bb_dir_next;
   logic                bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0]          bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0]         rdata_reg, rdata_next;
   logic                wake_reg, wake_next;
   logic [SYNC_W-1:0]   sync_in, sync_q, sync_rst;
   logic                do_write, do_read;
   logic [31:0]         status_word;

   // write needs address and data together; answer one cycle after
   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = ~rvalid_reg;
   assign do_write      = s_axi_awready;
   assign do_read       = s_axi_arvalid & s_axi_arready;

   assign status_word = {27'h0, wake_reg, uart_rx_busy, uart_tx_busy, usb_suspended, usb_configured};

   // byte-lane merge function
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction : merge

   // bus next state; unmapped write or read answers SLVERR
   always_comb begin
      ctrl_next   = ctrl_reg;
      func_next   = func_reg;
      bb_out_next = bb_out_reg;
      bb_dir_next = bb_dir_reg;
      bvalid_next = bvalid_reg & ~s_axi_bready;
      bresp_next  = bresp_reg;
      rvalid_next = rvalid_reg & ~s_axi_rready;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (do_write) begin
         bvalid_next = 1'b1;
         bresp_next  = 2'b00;
         case (s_axi_awaddr)
            `OFS_CTRL:    ctrl_next = merge(ctrl_reg, s_axi_wdata, s_axi_wstrb) & 32'h0000_001F;
            `OFS_FUNC_LO: func_next[31:0] = merge(func_reg[31:0], s_axi_wdata, s_axi_wstrb);
            `OFS_FUNC_HI: func_next[63:32] = merge(func_reg[63:32], s_axi_wdata, s_axi_wstrb);
            `OFS_BB_OUT:  bb_out_next = AUX_PINS'(merge(32'(bb_out_reg), s_axi_wdata, s_axi_wstrb));
            `OFS_BB_DIR:  bb_dir_next = AUX_PINS'(merge(32'(bb_dir_reg), s_axi_wdata, s_axi_wstrb));
            default:      bresp_next = 2'b10;
         endcase
      end
      if (do_read) begin
         rvalid_next = 1'b1;
         rresp_next  = 2'b00;
         case (s_axi_araddr)
            `OFS_CTRL:    rdata_next = ctrl_reg;
            `OFS_FUNC_LO: rdata_next = func_reg[31:0];
            `OFS_FUNC_HI: rdata_next = func_reg[63:32];
            `OFS_BB_OUT:  rdata_next = 32'(bb_out_reg);
            `OFS_BB_DIR:  rdata_next = 32'(bb_dir_reg);
            `OFS_STATUS:  rdata_next = status_word;
            `OFS_MODEM:   rdata_next = {28'h0, sync_q[4:1]};
            `OFS_BB_IN:   rdata_next = 32'(sync_q[SYNC_W-1:5]);
            default: begin
               rdata_next = 32'h0;
               rresp_next = 2'b10;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg   <= `CTRL_RESET;
         func_reg   <= 64'h0;
         bb_out_reg <= '0;
         bb_dir_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= 2'b00;
         rvalid_reg <= 1'b0;
         rresp_reg  <= 2'b00;
         rdata_reg  <= 32'h0;
      end else begin
         ctrl_reg   <= ctrl_next;
         func_reg   <= func_next;
         bb_out_reg <= bb_out_next;
         bb_dir_reg <= bb_dir_next;
         bvalid_reg <= bvalid_next;
         bresp_reg  <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg  <= rresp_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;

   // ------------------------------------------------------------
   // main port pins in serial mode (the only mode built here)
   // ------------------------------------------------------------
   // pin inputs: rxd, cts, dsr, dcd, ring, then aux inputs; idle level high
   assign sync_in  = {aux_port_pin_in, ring_indicator_n, carrier_detect_n, main_port_pin_dsr_n,
                      main_port_pin_cts_n, main_port_pin_rxd};
   assign sync_rst = {SYNC_W{1'b1}};

   aux_input_sync #(.WIDTH(SYNC_W)) u_sync (
      .clock     (clock),
      .rst       (rst),
      .async_in  (sync_in),
      .reset_val (sync_rst),
      .sync_out  (sync_q)
   );

   assign main_port_pin_txd   = uart_txd;                    // RULE12 RULE13
   assign uart_rxd            = sync_q[0];                   // RULE13
   assign uart_cts_n          = sync_q[1];                   // RULE13
   assign main_port_pin_rts_n = ctrl_reg[`CTRL_RTS_N];       // RULE13
   assign main_port_pin_dtr_n = ctrl_reg[`CTRL_DTR_N];       // RULE14

   // wake request: ring low in suspend, wake enabled, pull-down option off
   always_comb begin
      wake_next = usb_suspended & ctrl_reg[`CTRL_WAKE_EN]   // RULE15
                  & ~ctrl_reg[`CTRL_SUSP_PD] & ~sync_q[4];  // RULE16
   end

   always_ff @(posedge clock) begin
      if (rst) wake_reg <= 1'b0;
      else     wake_reg <= wake_next;
   end

   assign wake_request      = wake_reg;
   // gentle pull-down of inputs during suspend; the board keeps pull-ups when waking is used
   assign suspend_pull_down = usb_suspended & ctrl_reg[`CTRL_SUSP_PD];   // RULE17

   // ------------------------------------------------------------
   // activity pulse stretchers
   // ------------------------------------------------------------
   logic [31:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
   logic        tx_led_n, rx_led_n, traffic_n;

   // busy reloads a hold count so short frames still show a visible blink
   always_comb begin
      tx_cnt_next = uart_tx_busy ? 32'(LED_PULSE_CYC) : (tx_cnt_reg != 0 ? tx_cnt_reg - 32'd1 : 32'd0);
      rx_cnt_next = uart_rx_busy ? 32'(LED_PULSE_CYC) : (rx_cnt_reg != 0 ? rx_cnt_reg - 32'd1 : 32'd0);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_cnt_reg <= 32'h0;
         rx_cnt_reg <= 32'h0;
      end else begin
         tx_cnt_reg <= tx_cnt_next;
         rx_cnt_reg <= rx_cnt_next;
      end
   end

   assign tx_led_n  = ~(tx_cnt_reg != 0);       // RULE5
   assign rx_led_n  = ~(rx_cnt_reg != 0);       // RULE6
   assign traffic_n = tx_led_n & rx_led_n;      // RULE7

   // ------------------------------------------------------------
   // divided clocks from the 60 MHz source
   // ------------------------------------------------------------
   logic [2:0] div_reg;
   logic       susp_s1_reg, susp_s2_reg;

   // suspend crosses into the source domain through two flops before gating
   always_ff @(posedge src_clock) begin
      if (rst) begin
         div_reg     <= 3'h0;
         susp_s1_reg <= 1'b1;
         susp_s2_reg <= 1'b1;
      end else begin
         susp_s1_reg <= usb_suspended;
         susp_s2_reg <= susp_s1_reg;
         div_reg     <= susp_s2_reg ? div_reg : div_reg + 3'h1;   // RULE10
      end
   end

   // ------------------------------------------------------------
   // per-pin function selection
   // ------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < AUX_PINS; p++) begin : g_pin
         aux_func_t fn;
         always_comb begin
            // unconfigured pins fall back to the input defaults
            if (ctrl_reg[`CTRL_CFG_VALID])                                        // RULE1
               fn = aux_func_t'(func_reg[4*p +: 4]);
            else
               fn = (p == 7) ? FN_PULLED_DOWN : FN_PULLED_UP;                     // RULE2
            aux_port_pin_out[p]       = 1'b0;
            aux_port_pin_oe[p]        = 1'b1;
            aux_port_pin_pull_up[p]   = 1'b0;
            aux_port_pin_pull_down[p] = 1'b0;
            case (fn)
               FN_LINE_DRV:    aux_port_pin_out[p] = uart_tx_early;                // RULE3
               FN_POWER_ON:    aux_port_pin_out[p] = ~usb_configured | usb_suspended;   // RULE4
               FN_TX_LED:      aux_port_pin_out[p] = tx_led_n;
               FN_RX_LED:      aux_port_pin_out[p] = rx_led_n;
               FN_TRAFFIC_LED: aux_port_pin_out[p] = traffic_n;
               FN_SLEEP:       aux_port_pin_out[p] = ~usb_suspended;               // RULE8
               FN_CLK_HALF:    aux_port_pin_out[p] = div_reg[0];                   // RULE9
               FN_CLK_QUARTER: aux_port_pin_out[p] = div_reg[1];                   // RULE9
               FN_CLK_EIGHTH:  aux_port_pin_out[p] = div_reg[2];                   // RULE9
               FN_DRIVE_HIGH:  aux_port_pin_out[p] = 1'b1;                         // RULE11
               FN_DRIVE_LOW:   aux_port_pin_out[p] = 1'b0;                         // RULE11
               FN_BIT_BANG: begin
                  aux_port_pin_out[p] = bb_out_reg[p];                             // RULE11
                  aux_port_pin_oe[p]  = bb_dir_reg[p];
               end
               FN_PULLED_DOWN: begin
                  aux_port_pin_oe[p]        = 1'b0;
                  aux_port_pin_pull_down[p] = 1'b1;
               end
               default: begin
                  aux_port_pin_oe[p]      = 1'b0;                                  // RULE11
                  aux_port_pin_pull_up[p] = 1'b1;
               end
            endcase
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_ring_low_asleep;
      usb_suspended && ctrl_reg[`CTRL_WAKE_EN] && !ctrl_reg[`CTRL_SUSP_PD] && !sync_q[4];
   endsequence

   AST_WAKE: assert property (@(posedge clock) disable iff (rst)   // RULE15
      s_ring_low_asleep |=> wake_request) else $error("wake not requested");
   AST_NO_WAKE_PD: assert property (@(posedge clock) disable iff (rst)   // RULE16
      $past(ctrl_reg[`CTRL_SUSP_PD]) |-> !wake_request) else $error("wake with pull-down");
   AST_DEFAULT: assert property (@(posedge clock) disable iff (rst)   // RULE2
      !ctrl_reg[`CTRL_CFG_VALID] |-> !aux_port_pin_oe[0] && aux_port_pin_pull_up[0]
      && aux_port_pin_pull_down[7]) else $error("default pin roles wrong");
   AST_TX_LED: assert property (@(posedge clock) disable iff (rst)   // RULE5
      uart_tx_busy |=> !tx_led_n [*2]) else $error("tx led not lit");
   AST_RX_LED: assert property (@(posedge clock) disable iff (rst)   // RULE6
      uart_rx_busy |=> !rx_led_n) else $error("rx led not lit");
   AST_TRAFFIC: assert property (@(posedge clock) disable iff (rst)   // RULE7
      uart_tx_busy || uart_rx_busy |=> !traffic_n) else $error("traffic led not lit");
   AST_TXD: assert property (@(posedge clock) disable iff (rst)   // RULE13
      main_port_pin_txd == uart_txd) else $error("txd not routed");
   AST_CFG_USE: assert property (@(posedge clock) disable iff (rst)   // RULE1
      ctrl_reg[`CTRL_CFG_VALID] && func_reg[3:0] == 4'hB |-> aux_port_pin_oe[0] && !aux_port_pin_out[0])
      else $error("config not applied");
endmodule : aux_pin_function_mux

// ===== pkg/aux_mux_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the aux pin mux
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: definitions only
`ifndef AUX_MUX_CFG_SVH
`define AUX_MUX_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_FUNC_LO     8'h04
`define OFS_FUNC_HI     8'h08
`define OFS_BB_OUT      8'h0C
`define OFS_BB_DIR      8'h10
`define OFS_STATUS      8'h14
`define OFS_MODEM       8'h18
`define OFS_BB_IN       8'h1C
// ------------------------------------------------------------
// ctrl fields and reset values
// ------------------------------------------------------------
`define CTRL_CFG_VALID  0
`define CTRL_WAKE_EN    1
`define CTRL_SUSP_PD    2
`define CTRL_RTS_N      3
`define CTRL_DTR_N      4
`define CTRL_RESET      32'h0000_0018
// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define ST_CONFIGURED   0
`define ST_SUSPENDED    1
`define ST_TX_BUSY      2
`define ST_RX_BUSY      3
`define ST_WAKE_REQ     4
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LED_PULSE_MS    50
`define CLOCK_HZ        20000000
`define LED_PULSE_CYC   ((`LED_PULSE_MS * (`CLOCK_HZ / 1000)))
`define FUNC_W          4
`endif

// ===== pkg/aux_mux_pkg.sv
// Purpose: types shared by the aux pin mux design
// Assumes: nothing
// Notes: function codes are stored four bits per pin
package aux_mux_pkg;
   typedef enum logic [3:0] {
      FN_PULLED_UP   = 4'h0,
      FN_LINE_DRV    = 4'h1,
      FN_POWER_ON    = 4'h2,
      FN_TX_LED      = 4'h3,
      FN_RX_LED      = 4'h4,
      FN_TRAFFIC_LED = 4'h5,
      FN_SLEEP       = 4'h6,
      FN_CLK_HALF    = 4'h7,
      FN_CLK_QUARTER = 4'h8,
      FN_CLK_EIGHTH  = 4'h9,
      FN_DRIVE_HIGH  = 4'hA,
      FN_DRIVE_LOW   = 4'hB,
      FN_BIT_BANG    = 4'hC,
      FN_PULLED_DOWN = 4'hD
   } aux_func_t;
   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_RESP = 2'b01
   } axi_state_t;
endpackage : aux_mux_pkg

// ===== core/aux_input_sync.sv
// Purpose: three-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to clock
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module aux_input_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [WIDTH-1:0] out_next;

   // first stage feeds only the second; agreement filter on stages two and three
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
         end
      end
   endgenerate

   // every stage preset to the idle level, so release never shows a false edge
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_reg     <= reset_val;
         s2_reg     <= reset_val;
         s3_reg     <= reset_val;
         out_reg    <= reset_val;
      end else begin
         s1_reg     <= async_in;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         out_reg    <= out_next;
      end
   end

   assign sync_out = out_reg;
endmodule : aux_input_sync

// ===== verification/aux_far_side.sv
// Purpose: far-side board model: transceivers, leds, power switch, ring line
// Assumes: pins resolve from the mux enables and pulls
// Notes: a floating pin wanders every cycle so a stale level never passes
`timescale 1ns/1ps
module aux_far_side (
   input  wire logic       clock,
   input  wire logic [9:0] pin_out,
   input  wire logic [9:0] pin_oe,
   input  wire logic [9:0] pin_pu,
   input  wire logic [9:0] pin_pd,
   input  wire logic       ring_hold_low,
   output logic      [9:0] pin_level,
   output logic            ring_indicator_n
);
   logic float_reg = 1'b0;
   // wander source for undriven, unpulled pins
   always_ff @(posedge clock) begin
      float_reg <= ~float_reg;
   end
   // driver wins, then the pull resistor, else the pin floats
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : pin_pu[i] ? 1'b1 : pin_pd[i] ? 1'b0 : float_reg ^ i[0];
      end
   end
   // ring line rests on a board pull-up, suspend included
   assign ring_indicator_n = ~ring_hold_low;
endmodule : aux_far_side

// ===== verification/aux_pin_function_mux_tb_top.sv
// Purpose: self-checking bench for the aux pin function mux
// Assumes: 20 MHz clock, 60 MHz source clock, led stretch shortened to 8
// Notes: register access over AXI4-Lite; random levels from an lfsr
`timescale 1ns/1ps
module aux_pin_function_mux_tb_top;
   localparam int LED_CYC = 8;
   logic clock = 1'b0, rst = 1'b1, src_clock = 1'b0, ring_hold_low = 1'b0, ring_indicator_n;
   logic usb_configured = 1'b0, usb_suspended = 1'b0, uart_txd = 1'b1, uart_tx_early = 1'b0;
   logic uart_tx_busy = 1'b0, uart_rx_busy = 1'b0, main_port_pin_rxd = 1'b1, main_port_pin_cts_n = 1'b1;
   logic main_port_pin_dsr_n = 1'b1, carrier_detect_n = 1'b1;
   logic uart_rxd, uart_cts_n, main_port_pin_txd, main_port_pin_rts_n, main_port_pin_dtr_n, wake_request;
   logic suspend_pull_down, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [9:0] pin_level, aux_port_pin_out, aux_port_pin_oe, aux_port_pin_pull_up, aux_port_pin_pull_down;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'hB7975EF8;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   int error_cnt = 0, checks = 0, c6, c8, c9;

   initial forever #25 clock = ~clock;
   initial forever #8.333 src_clock = ~src_clock;

   aux_pin_function_mux #(.AUX_PINS(10), .LED_PULSE_CYC(LED_CYC)) DUT (
      .clock, .rst, .src_clock, .usb_configured, .usb_suspended, .uart_txd, .uart_tx_early,
      .uart_tx_busy, .uart_rx_busy, .uart_rxd, .uart_cts_n, .main_port_pin_txd, .main_port_pin_rxd,
      .main_port_pin_rts_n, .main_port_pin_cts_n, .main_port_pin_dtr_n, .main_port_pin_dsr_n,
      .carrier_detect_n, .ring_indicator_n, .wake_request, .suspend_pull_down,
      .aux_port_pin_in(pin_level), .aux_port_pin_out, .aux_port_pin_oe, .aux_port_pin_pull_up,
      .aux_port_pin_pull_down, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   aux_far_side far (.clock, .pin_out(aux_port_pin_out), .pin_oe(aux_port_pin_oe),
      .pin_pu(aux_port_pin_pull_up), .pin_pd(aux_port_pin_pull_down), .ring_hold_low,
      .pin_level, .ring_indicator_n);

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // power switch enable is low only while configured and awake
   function automatic logic power_exp(input logic cfg, input logic susp);
      return !(cfg && !susp);
   endfunction : power_exp

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // write: address and data offered together, response awaited under a bound
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin @(posedge clock); n++; end while (s_axi_awready !== 1'b1 && n < 50);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (s_axi_bvalid !== 1'b1 && n < 50) begin @(posedge clock); n++; end
      r = s_axi_bresp;
      if (n >= 50) begin chk(1'b0, "write hangs"); complete_run(); end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin @(posedge clock); n++; end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1 && n < 50) begin @(posedge clock); n++; end
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 50) begin chk(1'b0, "read hangs"); complete_run(); end
   endtask : axi_rd

   // count level changes on the three clock pins over 48 source periods
   task automatic count_edges;
      logic [9:0] p;
      c6 = 0; c8 = 0; c9 = 0;
      p = pin_level;
      repeat (48) begin
         @(negedge src_clock);
         c6 += int'(pin_level[6] !== p[6]);
         c8 += int'(pin_level[8] !== p[8]);
         c9 += int'(pin_level[9] !== p[9]);
         p = pin_level;
      end
      @(posedge clock);
   endtask : count_edges

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (5) @(posedge clock);
      chk(aux_port_pin_oe === 10'h000 && aux_port_pin_pull_up === 10'h37F, "default pulls");
      chk(aux_port_pin_pull_down === 10'h080, "pin seven pull-down");
      chk(main_port_pin_rts_n === 1'b1 && main_port_pin_dtr_n === 1'b1, "modem outs idle");
      axi_rd(8'h00, rd, rsp);
      chk(rd === 32'h0000_0018 && rsp === 2'b00, "ctrl reset");
      axi_wr(8'h04, 32'h0A65_4321, rsp);
      axi_wr(8'h08, 32'h0000_00CB, rsp);
      repeat (2) @(posedge clock);
      chk(aux_port_pin_oe === 10'h000, "functions held back without config");
      axi_wr(8'h00, 32'h0000_0019, rsp);
      axi_wr(8'h10, 32'h0000_0200, rsp);
      rd = {22'h0, seed[5], 9'h0};
      axi_wr(8'h0C, rd, rsp);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         usb_configured <= seed[0];
         usb_suspended <= seed[1];
         uart_tx_early <= seed[2];
         uart_txd <= seed[3];
         repeat (3) @(posedge clock);
         chk(pin_level[0] === seed[2], "line driver enable");
         chk(pin_level[1] === power_exp(seed[0], seed[1]), "power enable");
         chk(pin_level[5] === !seed[1], "sleep output");
         chk(main_port_pin_txd === seed[3], "txd path");
         chk(pin_level[6] === 1'b1 && pin_level[8] === 1'b0 && pin_level[7] === 1'b1, "fixed levels");
         chk(pin_level[9] === rd[9], "bit-bang");
      end
      usb_suspended <= 1'b0;
      for (int d = 0; d < 2; d++) begin
         uart_tx_busy <= (d == 0);
         uart_rx_busy <= (d == 1);
         repeat (6) @(posedge clock);
         chk(pin_level[2] === (d == 1) && pin_level[3] === (d == 0), "direction led");
         chk(pin_level[4] === 1'b0, "traffic led");
         uart_tx_busy <= 1'b0;
         uart_rx_busy <= 1'b0;
         repeat (3) @(posedge clock);
         chk(pin_level[4] === 1'b0, "led stretch");
         repeat (LED_CYC + 8) @(posedge clock);
         chk(pin_level[4:2] === 3'b111, "leds off");
      end
      axi_wr(8'h00, 32'h0000_0001, rsp);
      main_port_pin_rxd <= 1'b0;
      main_port_pin_cts_n <= 1'b0;
      main_port_pin_dsr_n <= 1'b0;
      repeat (6) @(posedge clock);
      chk(main_port_pin_rts_n === 1'b0 && main_port_pin_dtr_n === 1'b0, "modem outs");
      chk(uart_rxd === 1'b0 && uart_cts_n === 1'b0, "rxd cts in");
      axi_rd(8'h18, rd, rsp);
      chk(rd[3:0] === 4'hC, "modem status");
      axi_rd(8'h40, rd, rsp);
      chk(rsp === 2'b10, "unmapped read");
      axi_wr(8'h44, 32'hFFFF_FFFF, rsp);
      chk(rsp === 2'b10, "unmapped write");
      axi_wr(8'h00, 32'h0000_0003, rsp);
      usb_suspended <= 1'b1;
      ring_hold_low <= 1'b1;
      repeat (8) @(posedge clock);
      chk(wake_request === 1'b1, "ring wake");
      axi_rd(8'h14, rd, rsp);
      chk(rd[4:0] === {4'b1001, usb_configured}, "status word");
      axi_wr(8'h00, 32'h0000_0007, rsp);
      repeat (3) @(posedge clock);
      chk(wake_request === 1'b0 && suspend_pull_down === 1'b1, "pull-down blocks wake");
      ring_hold_low <= 1'b0;
      usb_suspended <= 1'b0;
      axi_wr(8'h04, 32'h0765_4321, rsp);
      axi_wr(8'h08, 32'h0000_0098, rsp);
      repeat (6) @(posedge clock);
      count_edges();
      chk(c6 >= 47 && c8 >= 23 && c8 <= 25 && c9 >= 11 && c9 <= 13, "divided clocks");
      usb_suspended <= 1'b1;
      repeat (10) @(posedge clock);
      count_edges();
      chk(c6 == 0 && c8 == 0 && c9 == 0, "clocks stop in suspend");
      complete_run();
   end
endmodule : aux_pin_function_mux_tb_top
